/* logic/ssd_driver.sv */
// forty-segment static display driver: serial shift, latches, blank, frame xor
`timescale 1ns/1ps
module ssd_driver #(
  parameter int unsigned SEGS  = ssd_pkg::SEG_NUM,
  parameter int unsigned DEPTH = ssd_pkg::FIFO_DEPTH
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  input  wire logic            serial_clk,
  input  wire logic            serial_in,
  input  wire logic            latch_load,
  input  wire logic            blank,
  input  wire logic            backplane_toggle_in,
  output logic                 serial_out,
  output logic      [SEGS-1:0] segment_outputs,
  output logic                 overrun
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [ssd_pkg::PIN_NUM-1:0][ssd_pkg::SYNC_DEPTH-1:0] sync;
    logic [ssd_pkg::PIN_NUM-1:0]                          filt;
    logic                                                 din_prev;
    logic                                                 pend_v;
    logic                                                 pend_bit;
    logic [SEGS-1:0]                                      shift;
    logic [SEGS-1:0]                                      latch;
    logic [SEGS-1:0]                                      seg;
    logic                                                 sout;
    logic                                                 ovr;
  } ssd_state_t;

  ssd_state_t st_q;
  ssd_state_t st_d;

  logic [ssd_pkg::PIN_NUM-1:0] pins;
  logic [ssd_pkg::PIN_NUM-1:0] agree;
  logic                        sclk_f;
  logic                        din_f;
  logic                        load_f;
  logic                        blank_f;
  logic                        frame_f;
  logic                        fall;
  logic                        fifo_in_ready;
  logic                        fifo_out_valid;
  logic [0:0]                  fifo_out_data;
  logic                        drain;

  assign pins[ssd_pkg::PIN_SCLK]  = serial_clk;
  assign pins[ssd_pkg::PIN_SIN]   = serial_in;
  assign pins[ssd_pkg::PIN_LOAD]  = latch_load;
  assign pins[ssd_pkg::PIN_BLANK] = blank;
  assign pins[ssd_pkg::PIN_FRAME] = backplane_toggle_in;

  assign sclk_f  = st_q.filt[ssd_pkg::PIN_SCLK];
  assign din_f   = st_q.filt[ssd_pkg::PIN_SIN];
  assign load_f  = st_q.filt[ssd_pkg::PIN_LOAD];
  assign blank_f = st_q.filt[ssd_pkg::PIN_BLANK];
  assign frame_f = st_q.filt[ssd_pkg::PIN_FRAME];

  // stages two and three agree: the level may be taken
  for (genvar g = 0; g < int'(ssd_pkg::PIN_NUM); g++)
  begin : g_agree
    assign agree[g] = (st_q.sync[g][ssd_pkg::TAP_MID] == st_q.sync[g][ssd_pkg::TAP_LAST]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge detect on the filtered serial clock

  // a fall on the filtered clock means stages two and three agree on a new low level
  assign fall = sclk_f &&
                (st_q.sync[ssd_pkg::PIN_SCLK][ssd_pkg::TAP_MID] ==
                 st_q.sync[ssd_pkg::PIN_SCLK][ssd_pkg::TAP_LAST]) &&
                !st_q.sync[ssd_pkg::PIN_SCLK][ssd_pkg::TAP_LAST];

  // shifting pauses while the strobe is high so the latches see a quiet register
  assign drain = fifo_out_valid && !load_f;

  ////////////////////////////////////////////////////////////////////////////
  // bit fifo between capture and shift register

  ssd_fifo #(
    .WIDTH (ssd_pkg::FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (st_q.pend_v),
    .in_ready  (fifo_in_ready),
    .in_data   (st_q.pend_bit),
    .out_valid (fifo_out_valid),
    .out_ready (drain),
    .out_data  (fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_d = st_q;
    for (int i = 0; i < int'(ssd_pkg::PIN_NUM); i++)
    begin
      st_d.sync[i] = {st_q.sync[i][ssd_pkg::SYNC_DEPTH-2:0], pins[i]};
      if (st_q.sync[i][ssd_pkg::TAP_MID] == st_q.sync[i][ssd_pkg::TAP_LAST])
      begin
        st_d.filt[i] = st_q.sync[i][ssd_pkg::TAP_LAST];
      end
    end

    // data seen just before the edge: zero hold time is honoured
    st_d.din_prev = din_f;

    // pending bit waits for fifo room; a new edge while still pending is an overrun
    if (st_q.pend_v && fifo_in_ready)
    begin
      st_d.pend_v = 1'b0;
    end
    if (fall)
    begin
      if (st_q.pend_v && !fifo_in_ready)
      begin
        st_d.ovr = 1'b1;
      end
      st_d.pend_v   = 1'b1;
      st_d.pend_bit = st_q.din_prev;
    end

    if (drain)
    begin
      st_d.shift = {st_q.shift[SEGS-2:0], fifo_out_data[0]};
    end

    st_d.sout = st_q.shift[SEGS-1];

    if (load_f)
    begin
      st_d.latch = st_q.shift;
    end

    if (blank_f)
    begin
      st_d.seg = ssd_pkg::SEG_RST;
    end
    else
    begin
      st_d.seg = st_q.latch ^ {SEGS{frame_f}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q          <= '0;
      st_q.shift    <= ssd_pkg::SEG_RST;
      st_q.latch    <= ssd_pkg::SEG_RST;
      st_q.seg      <= ssd_pkg::SEG_RST;
      st_q.sout     <= ssd_pkg::BIT_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign serial_out      = st_q.sout;
  assign segment_outputs = st_q.seg;
  assign overrun         = st_q.ovr;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_fall_capture: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fall |=> (st_q.pend_v && st_q.pend_bit == $past(st_q.din_prev)))
    else $error("falling edge did not capture the serial bit");

  a_one_per_edge: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fall |=> !fall)
    else $error("two captures from one serial clock edge");

  a_shift_in: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    drain |=> (st_q.shift == {$past(st_q.shift[SEGS-2:0]), $past(fifo_out_data[0])}))
    else $error("shift register did not take the next bit");

  a_shift_quiet: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !drain |=> $stable(st_q.shift))
    else $error("shift register moved without a serial bit");

  a_sout_last: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ##1 serial_out == $past(st_q.shift[SEGS-1]))
    else $error("serial output is not the last stage");

  a_latch_follow: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load_f [*2] |=> (st_q.latch == $past(st_q.shift)))
    else $error("open latches do not follow the register");

  a_latch_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !load_f |=> $stable(st_q.latch))
    else $error("closed latches changed");

  a_blank_low: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    blank_f |=> (segment_outputs == ssd_pkg::SEG_RST))
    else $error("segments not low while blanked");

  a_blank_keeps: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (blank_f && !load_f) ##1 !blank_f |=>
      (segment_outputs == ($past(st_q.latch, 2) ^ {SEGS{$past(frame_f)}})))
    else $error("blanking disturbed the latched data");

  a_seg_xor: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !blank_f |=> (segment_outputs == ($past(st_q.latch) ^ {SEGS{$past(frame_f)}})))
    else $error("segment is not latch xor backplane toggle");

  // pin filters: a level counts only once the last two stages agree

  a_sclk_filter: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !agree[ssd_pkg::PIN_SCLK] |=> $stable(sclk_f))
    else $error("serial clock level taken before its stages agreed");

  a_sin_filter: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !agree[ssd_pkg::PIN_SIN] |=> $stable(din_f))
    else $error("serial data level taken before its stages agreed");

  a_load_filter: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !agree[ssd_pkg::PIN_LOAD] |=> $stable(load_f))
    else $error("strobe level taken before its stages agreed");

  a_blank_filter: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !agree[ssd_pkg::PIN_BLANK] |=> $stable(blank_f))
    else $error("blank level taken before its stages agreed");

  a_frame_filter: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !agree[ssd_pkg::PIN_FRAME] |=> $stable(frame_f))
    else $error("backplane toggle level taken before its stages agreed");

  a_sclk_follow: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    agree[ssd_pkg::PIN_SCLK] |=>
      (sclk_f == $past(st_q.sync[ssd_pkg::PIN_SCLK][ssd_pkg::TAP_LAST])))
    else $error("serial clock filter missed an agreed level");

  a_sin_follow: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    agree[ssd_pkg::PIN_SIN] |=>
      (din_f == $past(st_q.sync[ssd_pkg::PIN_SIN][ssd_pkg::TAP_LAST])))
    else $error("serial data filter missed an agreed level");

  a_load_follow: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    agree[ssd_pkg::PIN_LOAD] |=>
      (load_f == $past(st_q.sync[ssd_pkg::PIN_LOAD][ssd_pkg::TAP_LAST])))
    else $error("strobe filter missed an agreed level");

  // capture, pending bit and overrun

  a_fall_level: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    fall |=> !sclk_f)
    else $error("falling edge seen but filtered clock stayed high");

  a_pend_hands: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st_q.pend_v && fifo_in_ready && !fall) |=> !st_q.pend_v)
    else $error("pending bit not handed to the fifo");

  a_pend_waits: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st_q.pend_v && !fifo_in_ready && !fall) |=> (st_q.pend_v && $stable(st_q.pend_bit)))
    else $error("pending bit lost while the fifo was full");

  a_ovr_set: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (fall && st_q.pend_v && !fifo_in_ready) |=> overrun)
    else $error("lost serial bit did not flag overrun");

  a_ovr_sticky: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    overrun |=> overrun)
    else $error("overrun flag cleared without reset");

  a_ovr_cause: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(overrun) |-> $past(fall && st_q.pend_v && !fifo_in_ready))
    else $error("overrun flagged without a lost bit");

  // register and latches around the strobe and blank

  a_shift_paused: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    load_f |=> $stable(st_q.shift))
    else $error("shift register moved while the latches were open");

  a_latch_blank: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (blank_f && !load_f) |=> $stable(st_q.latch))
    else $error("blanking altered the latches");

endmodule : ssd_driver

/* logic/ssd_fifo.sv */
// small parameterised fifo with valid and ready on both sides
`timescale 1ns/1ps
module ssd_fifo #(
  parameter int unsigned WIDTH = ssd_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = ssd_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } ssd_fifo_state_t;

  ssd_fifo_state_t st_q;
  ssd_fifo_state_t st_d;
  logic            full;
  logic            empty;
  logic            push;
  logic            pop;

  assign full      = (st_q.wr_ptr[AW] != st_q.rd_ptr[AW]) &&
                     (st_q.wr_ptr[AW-1:0] == st_q.rd_ptr[AW-1:0]);
  assign empty     = (st_q.wr_ptr == st_q.rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_q.mem[st_q.rd_ptr[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr_ptr[AW-1:0]] = in_data;
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule : ssd_fifo

/* logic/ssd_pkg.sv */
// constants shared by the serial segment driver and its fifo
package ssd_pkg;

  localparam int unsigned SEG_NUM    = 40;
  localparam int unsigned SYNC_DEPTH = 3;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FIFO_WIDTH = 1;

  // pin indices inside the synchroniser bank
  localparam int unsigned PIN_NUM    = 5;
  localparam int unsigned PIN_SCLK   = 0;
  localparam int unsigned PIN_SIN    = 1;
  localparam int unsigned PIN_LOAD   = 2;
  localparam int unsigned PIN_BLANK  = 3;
  localparam int unsigned PIN_FRAME  = 4;

  // synchroniser taps: second and third stages must agree before a change counts
  localparam int unsigned TAP_MID    = 1;
  localparam int unsigned TAP_LAST   = 2;

  // reset values
  localparam logic [SEG_NUM-1:0] SEG_RST   = 40'h00_0000_0000;
  localparam logic               BIT_RST   = 1'h0;

endpackage : ssd_pkg

/* sim/ssd_host_model.sv */
// host controller model driving serial, strobe, blank and frame pins
`timescale 1ns/1ps
module ssd_host_model (
  input  wire logic sys_clk,
  output logic      serial_clk,
  output logic      serial_in,
  output logic      latch_load,
  output logic      blank,
  output logic      backplane_toggle_in
);
  localparam int unsigned HALF = 4;

  initial
  begin
    serial_clk          = 1'h1;
    serial_in           = 1'h0;
    latch_load          = 1'h0;
    blank               = 1'h1;
    backplane_toggle_in = 1'h0;
  end

  task automatic wait_clk(input int unsigned n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_clk

  // clock idles high; released data shows the inverse of the last bit
  task automatic send_bit(input logic b);
    @(posedge sys_clk);
    serial_in  <= b;
    wait_clk(HALF);
    serial_clk <= 1'h0;
    wait_clk(HALF);
    serial_clk <= 1'h1;
    serial_in  <= ~b;
  endtask : send_bit

  task automatic strobe();
    @(posedge sys_clk);
    latch_load <= 1'h1;
    wait_clk(8);
    latch_load <= 1'h0;
    wait_clk(8);
  endtask : strobe

  task automatic hold_load(input logic v);
    @(posedge sys_clk);
    latch_load <= v;
    wait_clk(8);
  endtask : hold_load

  task automatic set_pins(input logic b, input logic f);
    @(posedge sys_clk);
    blank               <= b;
    backplane_toggle_in <= f;
    wait_clk(8);
  endtask : set_pins

endmodule : ssd_host_model

/* sim/tb_ssd_driver.sv */
// self-checking bench for the serial segment driver
`timescale 1ns/1ps
module tb_ssd_driver;
  localparam logic [39:0] PAT_A = 40'h96_A5C3_0F1E;
  localparam logic [39:0] PAT_B = 40'h5A_3C69_E187;

  logic        sys_clk;
  logic        rst_n;
  logic        serial_clk;
  logic        serial_in;
  logic        latch_load;
  logic        blank;
  logic        backplane_toggle_in;
  logic        serial_out;
  logic [39:0] segment_outputs;
  logic        overrun;
  int          miscompares;
  int          check_count;

  ssd_host_model ssd_host_model_inst (
    .sys_clk             (sys_clk),
    .serial_clk          (serial_clk),
    .serial_in           (serial_in),
    .latch_load          (latch_load),
    .blank               (blank),
    .backplane_toggle_in (backplane_toggle_in)
  );

  ssd_driver ssd_driver_inst (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .serial_clk          (serial_clk),
    .serial_in           (serial_in),
    .latch_load          (latch_load),
    .blank               (blank),
    .backplane_toggle_in (backplane_toggle_in),
    .serial_out          (serial_out),
    .segment_outputs     (segment_outputs),
    .overrun             (overrun)
  );

  initial
  begin
    sys_clk     = 1'h0;
    rst_n       = 1'h0;
    miscompares = 0;
    check_count = 0;
  end

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // first-sent bit ends at the last stage; the old frame leaves at serial_out
  task automatic load_frame(input logic [39:0] prev, input logic [39:0] data);
    logic [79:0] s;
    s = {prev, data};
    for (int i = 0; i < 40; i++)
    begin
      ssd_host_model_inst.send_bit(data[39-i]);
      ssd_host_model_inst.wait_clk(4);
      check("serial_out", {39'h0, serial_out}, {39'h0, s[78-i]});
    end
  endtask : load_frame

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    check("serial_out", {39'h0, serial_out}, 40'h00_0000_0000);
    check("segments", segment_outputs, 40'h00_0000_0000);
    check("overrun", {39'h0, overrun}, 40'h00_0000_0000);
    $display("test reset done");
  endtask : test_reset

  task automatic test_show();
    load_frame(40'h00_0000_0000, PAT_A);
    check("segments", segment_outputs, 40'h00_0000_0000);
    ssd_host_model_inst.strobe();
    ssd_host_model_inst.set_pins(1'h0, 1'h0);
    check("segments", segment_outputs, PAT_A);
    ssd_host_model_inst.set_pins(1'h0, 1'h1);
    check("segments", segment_outputs, ~PAT_A);
    $display("test show done");
  endtask : test_show

  task automatic test_hold();
    load_frame(PAT_A, PAT_B);
    check("segments", segment_outputs, ~PAT_A);
    ssd_host_model_inst.set_pins(1'h0, 1'h0);
    ssd_host_model_inst.strobe();
    check("segments", segment_outputs, PAT_B);
    $display("test hold done");
  endtask : test_hold

  task automatic test_blank();
    ssd_host_model_inst.set_pins(1'h1, 1'h1);
    check("segments", segment_outputs, 40'h00_0000_0000);
    ssd_host_model_inst.set_pins(1'h0, 1'h1);
    check("segments", segment_outputs, ~PAT_B);
    check("overrun", {39'h0, overrun}, 40'h00_0000_0000);
    $display("test blank done");
  endtask : test_blank

  // strobe held while clocking: bits queue in the fifo until the tenth edge overwrites the pending ninth bit
  task automatic test_overrun();
    ssd_host_model_inst.hold_load(1'h1);
    for (int i = 0; i < 9; i++)
    begin
      ssd_host_model_inst.send_bit(1'h1);
    end
    ssd_host_model_inst.wait_clk(4);
    check("overrun", {39'h0, overrun}, 40'h00_0000_0000);
    ssd_host_model_inst.send_bit(1'h1);
    ssd_host_model_inst.wait_clk(4);
    check("overrun", {39'h0, overrun}, 40'h00_0000_0001);
    check("segments", segment_outputs, ~PAT_B);
    ssd_host_model_inst.hold_load(1'h0);
    ssd_host_model_inst.wait_clk(8);
    check("segments", segment_outputs, ~PAT_B);
    check("overrun", {39'h0, overrun}, 40'h00_0000_0001);
    $display("test overrun done");
  endtask : test_overrun

  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    #1;
    test_reset();
    test_show();
    test_hold();
    test_blank();
    test_overrun();
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end

endmodule : tb_ssd_driver
